// ### hsh_pkg.sv
package hsh_pkg;

  // Homing method number as commanded by the drive
  localparam int METHOD_W = 8;
  typedef logic [METHOD_W-1:0] hsh_method_t;

  // Supported home-switch methods
  localparam hsh_method_t METHOD_23 = 8'h17;
  localparam hsh_method_t METHOD_24 = 8'h18;
  localparam hsh_method_t METHOD_25 = 8'h19;
  localparam hsh_method_t METHOD_26 = 8'h1A;
  localparam hsh_method_t METHOD_27 = 8'h1B;
  localparam hsh_method_t METHOD_28 = 8'h1C;
  localparam hsh_method_t METHOD_29 = 8'h1D;

  // Direction encoding on the motion command
  localparam logic DIR_POS = 1'h1;
  localparam logic DIR_NEG = 1'h0;

  // Synchroniser depth ahead of the edge stage
  localparam int SYNC_STAGES = 2;

  // Values after reset
  localparam logic RST_SWITCH = 1'h0;
  localparam logic RST_OUT    = 1'h0;

  // Sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_FAST     = 3'h1,
    ST_SLOW1    = 3'h3,
    ST_SLOW2    = 3'h2,
    ST_DONE     = 3'h6,
    ST_FAST_REV = 3'h5,
    ST_FAULT    = 3'h7
  } hsh_state_e;

endpackage : hsh_pkg

// ### hsh_switch_if.sv
`timescale 1ns/100ps
`default_nettype none

// Conditioned switch levels and edges between conditioner and sequencer
interface hsh_switch_if;
  logic homeSwitchLevel;
  logic homeRise;
  logic homeFall;
  logic posLimit;
  logic negLimit;

  modport producer (
    output homeSwitchLevel,
    output homeRise,
    output homeFall,
    output posLimit,
    output negLimit
  );

  modport consumer (
    input homeSwitchLevel,
    input homeRise,
    input homeFall,
    input posLimit,
    input negLimit
  );
endinterface : hsh_switch_if

`default_nettype wire

// ### hsh_switch_cond.sv
`timescale 1ns/100ps
`default_nettype none

module hsh_switch_cond
  import hsh_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Raw switch inputs
  input  wire logic        homeRaw,
  input  wire logic        posRaw,
  input  wire logic        negRaw,
  // Conditioned outputs
  hsh_switch_if.producer   sw
);

  // Edge of a level from two consecutive synchronised samples
  function automatic logic isRise(input logic now, input logic prev);
    isRise = now & ~prev;
  endfunction : isRise

  function automatic logic isFall(input logic now, input logic prev);
    isFall = ~now & prev;
  endfunction : isFall

  logic [SYNC_STAGES-1:0] homeSync;
  logic [SYNC_STAGES-1:0] posSync;
  logic [SYNC_STAGES-1:0] negSync;
  logic                   homePrev;

  // two-stage synchronisers
  // Stage 0 feeds only stage 1, to keep metastability out of the edges
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      homeSync <= {SYNC_STAGES{RST_SWITCH}};
      posSync  <= {SYNC_STAGES{RST_SWITCH}};
      negSync  <= {SYNC_STAGES{RST_SWITCH}};
      homePrev <= RST_SWITCH;
    end
    else
    begin
      homeSync <= {homeSync[SYNC_STAGES-2:0], homeRaw};
      posSync  <= {posSync[SYNC_STAGES-2:0], posRaw};
      negSync  <= {negSync[SYNC_STAGES-2:0], negRaw};
      homePrev <= homeSync[SYNC_STAGES-1];
    end
  end

  assign sw.homeSwitchLevel = homeSync[SYNC_STAGES-1];
  assign sw.homeRise        = isRise(homeSync[SYNC_STAGES-1], homePrev);
  assign sw.homeFall        = isFall(homeSync[SYNC_STAGES-1], homePrev);
  assign sw.posLimit        = posSync[SYNC_STAGES-1];
  assign sw.negLimit        = negSync[SYNC_STAGES-1];

endmodule : hsh_switch_cond

`default_nettype wire

// ### hsh_homing_seq.sv
`timescale 1ns/100ps
`default_nettype none

module hsh_homing_seq
  import hsh_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Homing command
  input  wire logic                 homingStart,
  input  wire logic                 homingAbort,
  input  wire hsh_pkg::hsh_method_t homingMethod,
  // Switch inputs
  input  wire logic                 homeSwitchRaw,
  input  wire logic                 posLimitRaw,
  input  wire logic                 negLimitRaw,
  // Motion command to the position loop
  output var  logic                 moveEnable,
  output var  logic                 moveDirPos,
  output var  logic                 moveFast,
  // Status
  output var  logic                 homingBusy,
  output var  logic                 homingDone,
  output var  logic                 homingFault
);

  // Direction of the high-speed search for a method
  function automatic logic fastDir(input hsh_method_t m);
    fastDir = (m <= METHOD_26) ? DIR_POS : DIR_NEG;
  endfunction : fastDir

  // Direction of the first low-speed pass, same with or without a limit hit
  function automatic logic slowDir(input hsh_method_t m);
    case (m)
      METHOD_25, METHOD_26, METHOD_27, METHOD_28: slowDir = DIR_POS;
      default:                                    slowDir = DIR_NEG;
    endcase
  endfunction : slowDir

  // Methods whose first low-speed falling edge is the home point
  function automatic logic stopOnFall(input hsh_method_t m);
    case (m)
      METHOD_23, METHOD_26, METHOD_27: stopOnFall = 1'h1;
      default:                         stopOnFall = 1'h0;
    endcase
  endfunction : stopOnFall

  // Conditioned switches
  // Switch events reach the outputs three edges after the raw pin
  hsh_switch_if sw ();

  hsh_switch_cond u_cond (
    .clk     (clk),
    .rst     (rst),
    .homeRaw (homeSwitchRaw),
    .posRaw  (posLimitRaw),
    .negRaw  (negLimitRaw),
    .sw      (sw)
  );

  hsh_state_e  state;
  hsh_state_e  next_state;
  hsh_method_t method;
  logic        dir;
  logic        next_dir;

  // Method is held for the whole run so a change mid-run has no effect
  // A start while busy is ignored; done and fault are left by a new start
  logic methodOk;
  logic startTaken;
  assign methodOk   = (homingMethod >= METHOD_23) && (homingMethod <= METHOD_29);
  assign startTaken = homingStart && !homingBusy;

  // Limit lying in the current direction of travel
  // After a reversal the limit just left still reads active for a few
  // cycles, so only the limit ahead may end a phase
  logic limitAhead;
  assign limitAhead = (dir == DIR_POS) ? sw.posLimit : sw.negLimit;

  // Decoded properties of the held method
  logic heldSlowDir;
  logic heldStopFall;
  assign heldSlowDir  = slowDir(method);
  assign heldStopFall = stopOnFall(method);

  // Next state and direction
  always_comb
  begin
    next_state = state;
    next_dir   = dir;
    case (state)
      ST_IDLE, ST_DONE, ST_FAULT:
      begin
        if (startTaken)
        begin
          if (!methodOk)
          begin
            next_state = ST_FAULT;
          end
          else if (sw.homeSwitchLevel)
          begin
            next_state = ST_SLOW1;
            next_dir   = slowDir(homingMethod);
          end
          else
          begin
            next_state = ST_FAST;
            next_dir   = fastDir(homingMethod);
          end
        end
      end
      ST_FAST:
      begin
        if (sw.homeRise)
        begin
          next_state = ST_SLOW1;
          next_dir   = heldSlowDir;
        end
        // A home edge wins over a limit in the same cycle: the switch
        // lies inside travel, so reversing there would skip it
        else if (limitAhead)
        begin
          next_state = ST_FAST_REV;
          next_dir   = ~dir;
        end
      end
      ST_FAST_REV:
      begin
        if (sw.homeRise)
        begin
          next_state = ST_SLOW1;
          next_dir   = heldSlowDir;
        end
        else if (limitAhead)
        begin
          // Both limits without a switch edge: the switch is missing
          next_state = ST_FAULT;
        end
      end
      ST_SLOW1:
      begin
        if (sw.homeFall)
        begin
          if (heldStopFall)
          begin
            next_state = ST_DONE;
          end
          else
          begin
            next_state = ST_SLOW2;
            next_dir   = ~heldSlowDir;
          end
        end
        else if (limitAhead)
        begin
          // Limit at low speed: the edge was missed, stop rather than run on
          next_state = ST_FAULT;
        end
      end
      ST_SLOW2:
      begin
        if (sw.homeRise)
        begin
          next_state = ST_DONE;
        end
        else if (limitAhead)
        begin
          // Same hazard on the return pass
          next_state = ST_FAULT;
        end
      end
      default:
      begin
        // Unused codes stop the axis instead of guessing a phase
        next_state = ST_FAULT;
      end
    endcase
    // Abort wins over every transition except a new start
    // so an abort while busy always leaves the axis stopped at the next edge
    if (homingAbort && homingBusy)
    begin
      next_state = ST_IDLE;
    end
  end

  // Decoded motion outputs of the next state
  // Busy equals motion: done and fault both leave the axis stopped
  logic next_moving;
  logic next_fast;
  assign next_moving = (next_state == ST_FAST) || (next_state == ST_FAST_REV) ||
                       (next_state == ST_SLOW1) || (next_state == ST_SLOW2);
  assign next_fast   = (next_state == ST_FAST) || (next_state == ST_FAST_REV);

  // Direction and status of the next state; direction reads 0 while stopped
  logic next_dirPos;
  logic next_done;
  logic next_fault;
  assign next_dirPos = next_moving & next_dir;
  assign next_done   = (next_state == ST_DONE);
  assign next_fault  = (next_state == ST_FAULT);

  // State and travel direction
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      dir   <= DIR_NEG;
    end
    else
    begin
      state <= next_state;
      dir   <= next_dir;
    end
  end

  // Method held from the accepted start; the phases decode this copy only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      method <= METHOD_23;
    end
    else if (startTaken)
    begin
      method <= homingMethod;
    end
  end

  // Registered outputs, aligned with the state register
  // Decoding the next state costs a little logic but keeps every output
  // on a flop with no cycle of lag behind the state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      moveEnable  <= RST_OUT;
      moveDirPos  <= RST_OUT;
      moveFast    <= RST_OUT;
      homingBusy  <= RST_OUT;
      homingDone  <= RST_OUT;
      homingFault <= RST_OUT;
    end
    else
    begin
      moveEnable  <= next_moving;
      moveDirPos  <= next_dirPos;
      moveFast    <= next_fast;
      homingBusy  <= next_moving;
      homingDone  <= next_done;
      homingFault <= next_fault;
    end
  end

endmodule : hsh_homing_seq

`default_nettype wire

// ### hsh_homing_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module hsh_homing_monitor
  import hsh_pkg::*;
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // Command
  input wire logic                 homingStart,
  input wire logic                 homingAbort,
  input wire hsh_pkg::hsh_method_t homingMethod,
  // Switches
  input wire logic                 homeSwitchRaw,
  input wire logic                 posLimitRaw,
  input wire logic                 negLimitRaw,
  // Motion and status
  input wire logic                 moveEnable,
  input wire logic                 moveDirPos,
  input wire logic                 moveFast,
  input wire logic                 homingBusy,
  input wire logic                 homingDone,
  input wire logic                 homingFault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Accepted start and supported method
  wire logic take = homingStart && !homingBusy && !homingAbort;
  wire logic good = homingMethod >= METHOD_23 && homingMethod <= METHOD_29;

  a_busy_is_motion:
    assert property (homingBusy == moveEnable) else $error("busy and motion differ");
  a_search_start:
    assert property ((!homeSwitchRaw)[*4] ##0 (take && good)
      |=> moveFast && moveDirPos == ($past(homingMethod) <= METHOD_26))
    else $error("wrong fast search start");
  a_active_slow:
    assert property (homeSwitchRaw[*4] ##0 (take && good) |=> moveEnable && !moveFast)
    else $error("active start not slow");
  a_bad_method:
    assert property (take && !good |=> homingFault && !moveEnable)
    else $error("bad method moved");
  a_abort_idle:
    assert property (homingBusy && homingAbort |=> !homingBusy && !homingDone)
    else $error("abort ignored");
  a_status_hold:
    assert property ((homingDone || homingFault) && !homingStart
      |=> $stable({homingDone, homingFault})) else $error("status dropped");
  a_limit_flip:
    assert property ((!homeSwitchRaw)[*3] ##0 ($rose(posLimitRaw) && moveFast && moveDirPos)
      |-> ##3 !moveDirPos) else $error("limit not reversed");
  a_done_slow:
    assert property ($rose(homingDone)
      |-> !homingBusy && $past(moveEnable) && !$past(moveFast))
    else $error("stop not from low speed");

  // Main scenarios reached
  c_started: cover property (take && good);
  c_limit:   cover property ((posLimitRaw || negLimitRaw) && moveFast);
  c_done:    cover property ($rose(homingDone));
endmodule : hsh_homing_monitor

bind hsh_homing_seq hsh_homing_monitor hsh_homing_monitor_i (
  .clk(clk), .rst(rst), .homingStart(homingStart), .homingAbort(homingAbort),
  .homingMethod(homingMethod), .homeSwitchRaw(homeSwitchRaw),
  .posLimitRaw(posLimitRaw), .negLimitRaw(negLimitRaw), .moveEnable(moveEnable),
  .moveDirPos(moveDirPos), .moveFast(moveFast), .homingBusy(homingBusy),
  .homingDone(homingDone), .homingFault(homingFault));

`default_nettype wire

// ### hsh_motor_model.sv
`timescale 1ns/100ps
`default_nettype none

module hsh_motor_model (
  // Clock
  input  wire logic clk,
  // Position preset
  input  wire logic load,
  input  var  int   loadPos,
  // Motion command
  input  wire logic moveEnable,
  input  wire logic moveDirPos,
  input  wire logic moveFast,
  // Switch levels
  output logic      homeSwitchRaw,
  output logic      posLimitRaw,
  output logic      negLimitRaw
);
  int pos = 0;

  // Fast steps overshoot every switch edge, as a real axis would
  always @(posedge clk)
    if (load)
      pos <= loadPos;
    else if (moveEnable)
      pos <= pos + (moveDirPos ? 1 : -1) * (moveFast ? 4 : 1);

  assign homeSwitchRaw = pos >= 200 && pos <= 260;
  assign posLimitRaw   = pos >= 400;
  assign negLimitRaw   = pos <= 0;
endmodule : hsh_motor_model

`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    cmpCount++; \
    if ((got) !== (exp)) \
    begin \
      nMismatch++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end

module testbench;
  import hsh_pkg::*;

  // Stimulus, switches and outputs
  logic        clk, rst, homingStart, homingAbort, load;
  hsh_method_t homingMethod;
  int          loadPos;
  logic        homeSwitchRaw, posLimitRaw, negLimitRaw;
  logic        moveEnable, moveDirPos, moveFast, homingBusy, homingDone, homingFault;
  int          nMismatch;
  int          cmpCount;
  logic [1:0]  seen[$];
  logic [1:0]  expQ[$];

  hsh_homing_seq hsh_homing_seq_i (
    .clk(clk), .rst(rst), .homingStart(homingStart), .homingAbort(homingAbort),
    .homingMethod(homingMethod), .homeSwitchRaw(homeSwitchRaw),
    .posLimitRaw(posLimitRaw), .negLimitRaw(negLimitRaw), .moveEnable(moveEnable),
    .moveDirPos(moveDirPos), .moveFast(moveFast), .homingBusy(homingBusy),
    .homingDone(homingDone), .homingFault(homingFault));
  hsh_motor_model hsh_motor_model_i (
    .clk(clk), .load(load), .loadPos(loadPos), .moveEnable(moveEnable),
    .moveDirPos(moveDirPos), .moveFast(moveFast), .homeSwitchRaw(homeSwitchRaw),
    .posLimitRaw(posLimitRaw), .negLimitRaw(negLimitRaw));

  always #5 clk = ~clk;

  // Log each new direction and speed pair
  always @(posedge clk)
    if (moveEnable && (seen.size() == 0 || seen[$] !== {moveDirPos, moveFast}))
      seen.push_back({moveDirPos, moveFast});

  // Phase list: fast search, fast reversal on a limit, then low-speed passes
  function automatic void build_exp(input hsh_method_t m, input int cs);
    logic pf;
    pf = m <= METHOD_26;
    expQ.delete();
    if (cs != 2) expQ.push_back({pf, 1'h1});
    if (cs == 1) expQ.push_back({!pf, 1'h1});
    expQ.push_back((m == METHOD_23 || m == METHOD_24 || m == METHOD_29) ? 2'h0 : 2'h2);
    if (m == METHOD_24 || m == METHOD_29) expQ.push_back(2'h2);
    if (m == METHOD_25 || m == METHOD_28) expQ.push_back(2'h0);
  endfunction : build_exp

  // Case 0 clear path, 1 via a limit, 2 switch active at start
  task automatic run_case(input hsh_method_t m, input int cs, input bit ab);
    int r;
    int w;
    r = $urandom % 60;
    w = 0;
    load <= 1'h1;
    loadPos <= (cs == 2) ? 205 + r % 50 : (((cs == 0) == (m <= METHOD_26)) ? 100 : 300) + r;
    @(posedge clk);
    load <= 1'h0;
    repeat (4) @(posedge clk);
    seen.delete();
    homingMethod <= m;
    homingStart <= 1'h1;
    @(posedge clk);
    homingStart <= 1'h0;
    if (ab)
    begin
      // A start while busy must be ignored, bad method and all
      repeat (5) @(posedge clk);
      homingMethod <= 8'h1E;
      homingStart <= 1'h1;
      @(posedge clk);
      homingStart <= 1'h0;
      repeat (4) @(posedge clk);
      `CHECK({homingBusy, homingFault}, 2'h2);
      homingAbort <= 1'h1;
      @(posedge clk);
      homingAbort <= 1'h0;
      @(posedge clk);
      `CHECK({homingBusy, homingDone}, 2'h0);
      return;
    end
    // Done of the last run still reads high at the start edge, so wait first
    do
    begin
      @(posedge clk);
      w++;
    end
    while (homingDone !== 1'h1 && w < 2000);
    build_exp(m, cs);
    `CHECK(seen.size(), expQ.size());
    foreach (expQ[i]) `CHECK(seen[i], expQ[i]);
    `CHECK({homingDone, homingBusy, homingFault}, 3'h4);
  endtask : run_case

  task automatic finish_test();
    if (nMismatch == 0 && cmpCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Main sequence: every method and start case, random mix, refusals
  initial
  begin
    clk = 1'h0;
    rst = 1'h1;
    {homingStart, homingAbort, load} = 3'h0;
    homingMethod = METHOD_23;
    loadPos = 100;
    nMismatch = 0;
    cmpCount = 0;
    void'($urandom(67));
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    for (int m = METHOD_23; m <= METHOD_29; m++)
      for (int c = 0; c < 3; c++)
        run_case(hsh_method_t'(m), c, 1'h0);
    repeat (8) run_case(hsh_method_t'(METHOD_23 + $urandom % 7), $urandom % 3, 1'h0);
    run_case(METHOD_29, 1, 1'h1);
    homingMethod <= 8'h1E;
    homingStart <= 1'h1;
    @(posedge clk);
    homingStart <= 1'h0;
    @(posedge clk);
    `CHECK({homingFault, moveEnable}, 2'h2);
    finish_test();
  end

  // Watchdog against a hung sequence
  initial
  begin
    repeat (50000) @(posedge clk);
    nMismatch++;
    finish_test();
  end
endmodule : testbench

`default_nettype wire
